/* shared/ccal_consts.svh */
// Register map, field positions and timing constants of the clock/calendar block
`ifndef CCAL_CONSTS_SVH
`define CCAL_CONSTS_SVH

// Register word addresses
`define CCAL_ADDR_CFG 4'h0
`define CCAL_ADDR_TIME 4'h1
`define CCAL_ADDR_ALCFG 4'h2
`define CCAL_ADDR_ALVAL 4'h3
`define CCAL_ADDR_PAD 4'h4
`define CCAL_ADDR_KEY 4'h5

// Configuration / drift trim register fields
`define CCAL_CFG_ON 15
`define CCAL_CFG_UNLOCK 13
`define CCAL_CFG_RIPPLE 12
`define CCAL_CFG_HALF 11
`define CCAL_CFG_PINOE 10
`define CCAL_CFG_PTR_HI 9
`define CCAL_CFG_PTR_LO 8

// Alarm configuration / repeat register fields
`define CCAL_AL_ON 15
`define CCAL_AL_ENDLESS 14
`define CCAL_AL_MASK_HI 13
`define CCAL_AL_MASK_LO 10
`define CCAL_AL_PTR_HI 9
`define CCAL_AL_PTR_LO 8

// Pad output config fields
`define CCAL_PAD_SEL_HI 2
`define CCAL_PAD_SEL_LO 1

// Window pointer codes
`define CCAL_PTR_MINUTES_SECONDS_REG 2'h0
`define CCAL_PTR_WDHR 2'h1
`define CCAL_PTR_MTHDY 2'h2
`define CCAL_PTR_YEAR 2'h3

// Pin signal select codes
`define CCAL_PINSEL_ALARM 2'h0
`define CCAL_PINSEL_SECS 2'h1
`define CCAL_PINSEL_TICK 2'h2

// Unlock key sequence
`define CCAL_KEY_FIRST 8'h55
`define CCAL_KEY_SECOND 8'hAA

// Tick counts
`define CCAL_TICKS_PER_SEC 16'h8000
`define CCAL_RIPPLE_TICKS 16'h0020

// BCD limits
`define CCAL_BCD_59 8'h59
`define CCAL_BCD_23 8'h23
`define CCAL_BCD_06 8'h06
`define CCAL_BCD_12 8'h12
`define CCAL_BCD_99 8'h99
`define CCAL_BCD_01 8'h01
`define CCAL_BCD_00 8'h00

`endif

/* shared/ccal_pkg.sv */
// Types shared by the clock/calendar block and its bench
`default_nettype none
package ccal_pkg;

  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } ccal_time_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [1:0] byteEn;
    logic wr;
    logic rd;
  } ccal_bus_t;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_FIRST,
    UNL_ARMED
  } ccal_unlock_t;

endpackage

`default_nettype wire

/* rtl/clock_calendar_alarm.sv */
// Clock/calendar with alarm, drift trim, unlock gate and pin output
//
// Functional notes
// - High-byte time window write steps value pointer down, holding at 00.
// - Value pointer: 00 min/sec, 01 wday/hour, 10 month/day, 11 year low.
// - High-byte alarm window write steps alarm pointer down, holding at 00.
// - Any read of either window steps its pointer down.
// - Time window writes ignored unless unlock bit 13 set.
// - Unlock bit sets only right after 55h then AAh key writes.
// - Enable bit 15 runs the calendar; writable only while unlocked.
// - Ripple flag bit 12 high while reads may catch a rollover.
// - Half-second flag bit 11 shows second half; seconds write clears it.
// - Output-enable bit 10 gates the selected signal onto the pin.
// - Signed trim adds or removes four ticks per unit once a minute.
// - Config register reset only by power-on reset.
// - Strap picks tick source: 1 crystal, 0 internal oscillator.
// - Counting continues while the external reset is held.
// - Pin select: 00 alarm, 01 seconds clock, 10 raw tick.
// - Endless repeat wraps count 00h to FFh; otherwise stops at 00h.
// - Interval mask codes half second up to year; higher codes reserved.
// - Repeat count decrements each event; alarm repeats while nonzero.
// - Calendar years 2000-2099 with leap-year February 29.
// - Hours in 24-hour format; all fields BCD.
// - Seconds tens digit three bits 0-5, ones digit four bits 0-9.
`timescale 1ns/10ps
`default_nettype none
`include "ccal_consts.svh"

module clock_calendar_alarm
  import ccal_pkg::*;
#(
  parameter logic [15:0] TICKS_PER_SEC = `CCAL_TICKS_PER_SEC
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic rst, // External reset pin, synchronous, active high
  input wire logic porRst, // Power-on reset, synchronous, active high
  input wire ccal_bus_t bus, // Register bus request
  output logic [15:0] rdData, // Read data, valid the cycle after a read
  input wire logic crystalTick, // Secondary crystal oscillator, async
  input wire logic lowPowerTick, // Internal low-power oscillator, async
  input wire logic tickSourceStrap, // Nonvolatile tick source select bit
  output logic pinOut, // Calendar output pin level
  output logic pinOutEn // Calendar output pin enable
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] bcdInc(input logic [7:0] v, input logic [7:0] maxv, input logic [7:0] minv);
    if (v >= maxv) begin
      bcdInc = minv;
    end else if (v[3:0] == 4'h9) begin
      bcdInc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcdInc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Year is BCD 00-99 for 2000-2099, so divisibility by four suffices
  function automatic logic isLeap(input logic [7:0] y);
    if (y[4]) begin
      isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] monthDays(input logic [4:0] m, input logic [7:0] y);
    case ({3'h0, m})
      8'h02: monthDays = isLeap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: monthDays = 8'h30;
      default: monthDays = 8'h31;
    endcase
  endfunction

  function automatic logic [1:0] ptrDown(input logic [1:0] p);
    ptrDown = (p == `CCAL_PTR_MINUTES_SECONDS_REG) ? `CCAL_PTR_MINUTES_SECONDS_REG : p - 2'h1;
  endfunction

  // ---------------------------------------------------------------
  // Tick source synchronisers and strap capture
  // ---------------------------------------------------------------
  logic xtalMeta_ff, xtalSync_ff, lprcMeta_ff, lprcSync_ff, strapMeta_ff, strapSync_ff;
  logic srcSel_ff, srcLatched_ff, tickPrev_ff;
  logic tickLevel, tickEdge;

  // No reset: counting must survive the external reset
  always_ff @(posedge clk) begin
    xtalMeta_ff <= crystalTick;
    xtalSync_ff <= xtalMeta_ff;
    lprcMeta_ff <= lowPowerTick;
    lprcSync_ff <= lprcMeta_ff;
    strapMeta_ff <= tickSourceStrap;
    strapSync_ff <= strapMeta_ff;
  end

  always_ff @(posedge clk) begin
    if (porRst) begin
      srcSel_ff <= 1'b0;
      srcLatched_ff <= 1'b0;
    end else if (!srcLatched_ff) begin
      srcSel_ff <= strapSync_ff;
      srcLatched_ff <= 1'b1;
    end
  end

  assign tickLevel = srcSel_ff ? xtalSync_ff : lprcSync_ff;
  assign tickEdge = tickLevel & ~tickPrev_ff;

  always_ff @(posedge clk) begin
    if (porRst) begin
      tickPrev_ff <= 1'b0;
    end else begin
      tickPrev_ff <= tickLevel;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic wrCfg, wrTime, wrAlCfg, wrAlVal, wrPad, wrKey, rdTime, rdAlVal;
  logic wrHi, wrLo;
  assign wrHi = bus.wr & bus.byteEn[1];
  assign wrLo = bus.wr & bus.byteEn[0];
  assign wrCfg = bus.wr && bus.addr == `CCAL_ADDR_CFG;
  assign wrTime = bus.wr && bus.addr == `CCAL_ADDR_TIME;
  assign wrAlCfg = bus.wr && bus.addr == `CCAL_ADDR_ALCFG;
  assign wrAlVal = bus.wr && bus.addr == `CCAL_ADDR_ALVAL;
  assign wrPad = bus.wr && bus.addr == `CCAL_ADDR_PAD;
  assign wrKey = wrLo && bus.addr == `CCAL_ADDR_KEY;
  assign rdTime = bus.rd && bus.addr == `CCAL_ADDR_TIME;
  assign rdAlVal = bus.rd && bus.addr == `CCAL_ADDR_ALVAL;

  // ---------------------------------------------------------------
  // Unlock key sequence
  // ---------------------------------------------------------------
  ccal_unlock_t unlockState_ff;

  // Any other write breaks the sequence; the arm lasts one cycle only
  always_ff @(posedge clk) begin
    if (porRst || rst) begin
      unlockState_ff <= UNL_IDLE;
    end else begin
      case (unlockState_ff)
        UNL_IDLE: begin
          if (wrKey && bus.wdata[7:0] == `CCAL_KEY_FIRST) begin
            unlockState_ff <= UNL_GOT_FIRST;
          end
        end
        UNL_GOT_FIRST: begin
          if (wrKey && bus.wdata[7:0] == `CCAL_KEY_SECOND) begin
            unlockState_ff <= UNL_ARMED;
          end else if (bus.wr) begin
            unlockState_ff <= UNL_IDLE;
          end
        end
        UNL_ARMED: unlockState_ff <= UNL_IDLE;
        default: unlockState_ff <= UNL_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration and drift trim register
  // ---------------------------------------------------------------
  logic calOn_ff, unlock_ff, pinOe_ff;
  logic [1:0] timePtr_ff;
  logic [7:0] trim_ff;

  // Only power-on reset touches this register
  always_ff @(posedge clk) begin
    if (porRst) begin
      calOn_ff <= 1'b0;
      unlock_ff <= 1'b0;
      pinOe_ff <= 1'b0;
      timePtr_ff <= `CCAL_PTR_MINUTES_SECONDS_REG;
      trim_ff <= 8'h00;
    end else begin
      if (wrCfg && wrHi) begin
        if (unlock_ff) begin
          calOn_ff <= bus.wdata[`CCAL_CFG_ON];
        end
        unlock_ff <= bus.wdata[`CCAL_CFG_UNLOCK] & (unlock_ff | (unlockState_ff == UNL_ARMED));
        pinOe_ff <= bus.wdata[`CCAL_CFG_PINOE];
        timePtr_ff <= bus.wdata[`CCAL_CFG_PTR_HI:`CCAL_CFG_PTR_LO];
      end else if (rdTime || (wrTime && wrHi)) begin
        timePtr_ff <= ptrDown(timePtr_ff);
      end
      if (wrCfg && wrLo) begin
        trim_ff <= bus.wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler with once-a-minute drift trim
  // ---------------------------------------------------------------
  logic [15:0] subCnt_ff;
  logic signed [9:0] trimLeft_ff;
  logic [16:0] stepSum;
  logic [1:0] step;
  logic secTick, halfTick, halfPhase, ripple, minuteWrap;
  logic [15:0] halfPoint;

  assign halfPoint = {1'b0, TICKS_PER_SEC[15:1]};
  // Positive trim advances two per tick, negative trim swallows a tick
  assign step = !tickEdge ? 2'd0 : (trimLeft_ff > 10'sd0) ? 2'd2 : (trimLeft_ff < 10'sd0) ? 2'd0 : 2'd1;
  assign stepSum = {1'b0, subCnt_ff} + {15'h0, step};
  assign secTick = calOn_ff && stepSum >= {1'b0, TICKS_PER_SEC};
  assign halfTick = secTick || (calOn_ff && subCnt_ff < halfPoint && stepSum[15:0] >= halfPoint);
  assign halfPhase = subCnt_ff >= halfPoint;
  assign ripple = subCnt_ff >= TICKS_PER_SEC - `CCAL_RIPPLE_TICKS;

  always_ff @(posedge clk) begin
    if (porRst) begin
      subCnt_ff <= 16'h0000;
    end else if (wrTime && wrLo && unlock_ff && timePtr_ff == `CCAL_PTR_MINUTES_SECONDS_REG) begin
      subCnt_ff <= 16'h0000;
    end else if (secTick) begin
      subCnt_ff <= 16'(stepSum - {1'b0, TICKS_PER_SEC});
    end else if (calOn_ff) begin
      subCnt_ff <= stepSum[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (porRst) begin
      trimLeft_ff <= 10'sd0;
    end else if (minuteWrap) begin
      trimLeft_ff <= {trim_ff, 2'b00};
    end else if (calOn_ff && tickEdge && trimLeft_ff > 10'sd0) begin
      trimLeft_ff <= trimLeft_ff - 10'sd1;
    end else if (calOn_ff && tickEdge && trimLeft_ff < 10'sd0) begin
      trimLeft_ff <= trimLeft_ff + 10'sd1;
    end
  end

  // ---------------------------------------------------------------
  // Time and date counters
  // ---------------------------------------------------------------
  ccal_time_t now_ff, nxt_now;
  logic [7:0] dayMax;

  assign dayMax = monthDays(now_ff.month, now_ff.year);
  assign minuteWrap = secTick && {1'b0, now_ff.sec} >= `CCAL_BCD_59;

  always_comb begin
    nxt_now = now_ff;
    if (secTick) begin
      nxt_now.sec = 7'(bcdInc({1'b0, now_ff.sec}, `CCAL_BCD_59, `CCAL_BCD_00));
      if (minuteWrap) begin
        nxt_now.min = 7'(bcdInc({1'b0, now_ff.min}, `CCAL_BCD_59, `CCAL_BCD_00));
        if ({1'b0, now_ff.min} >= `CCAL_BCD_59) begin
          nxt_now.hour = 6'(bcdInc({2'b0, now_ff.hour}, `CCAL_BCD_23, `CCAL_BCD_00));
          if ({2'b0, now_ff.hour} >= `CCAL_BCD_23) begin
            nxt_now.wday = 3'(bcdInc({5'b0, now_ff.wday}, `CCAL_BCD_06, `CCAL_BCD_00));
            nxt_now.day = 6'(bcdInc({2'b0, now_ff.day}, dayMax, `CCAL_BCD_01));
            if ({2'b0, now_ff.day} >= dayMax) begin
              nxt_now.month = 5'(bcdInc({3'b0, now_ff.month}, `CCAL_BCD_12, `CCAL_BCD_01));
              if ({3'b0, now_ff.month} >= `CCAL_BCD_12) begin
                nxt_now.year = bcdInc(now_ff.year, `CCAL_BCD_99, `CCAL_BCD_00);
              end
            end
          end
        end
      end
    end
    if (wrTime && unlock_ff) begin
      case (timePtr_ff)
        `CCAL_PTR_MINUTES_SECONDS_REG: begin
          if (wrHi) nxt_now.min = bus.wdata[14:8];
          if (wrLo) nxt_now.sec = bus.wdata[6:0];
        end
        `CCAL_PTR_WDHR: begin
          if (wrHi) nxt_now.wday = bus.wdata[10:8];
          if (wrLo) nxt_now.hour = bus.wdata[5:0];
        end
        `CCAL_PTR_MTHDY: begin
          if (wrHi) nxt_now.month = bus.wdata[12:8];
          if (wrLo) nxt_now.day = bus.wdata[5:0];
        end
        default: begin
          if (wrLo) nxt_now.year = bus.wdata[7:0];
        end
      endcase
    end
  end

  // Counters keep running through the external reset
  always_ff @(posedge clk) begin
    if (porRst) begin
      now_ff <= '{year: 8'h00, month: 5'h01, day: 6'h01, wday: 3'h0, hour: 6'h00, min: 7'h00, sec: 7'h00};
    end else begin
      now_ff <= nxt_now;
    end
  end

  // ---------------------------------------------------------------
  // Alarm configuration and alarm value registers
  // ---------------------------------------------------------------
  logic alarmOn_ff, endless_ff;
  logic [3:0] mask_ff;
  logic [1:0] alPtr_ff;
  logic [7:0] repeat_ff;
  ccal_time_t alarm_ff;
  logic alarmEvent, evalPend_ff, evalSec_ff, matchHit;

  always_ff @(posedge clk) begin
    if (porRst) begin
      alarm_ff <= '0;
    end else if (wrAlVal) begin
      case (alPtr_ff)
        `CCAL_PTR_MINUTES_SECONDS_REG: begin
          if (wrHi) alarm_ff.min <= bus.wdata[14:8];
          if (wrLo) alarm_ff.sec <= bus.wdata[6:0];
        end
        `CCAL_PTR_WDHR: begin
          if (wrHi) alarm_ff.wday <= bus.wdata[10:8];
          if (wrLo) alarm_ff.hour <= bus.wdata[5:0];
        end
        `CCAL_PTR_MTHDY: begin
          if (wrHi) alarm_ff.month <= bus.wdata[12:8];
          if (wrLo) alarm_ff.day <= bus.wdata[5:0];
        end
        default: alarm_ff.year <= 8'h00;
      endcase
    end
  end

  // Software writes lose against a same-cycle alarm event on the enable and count
  always_ff @(posedge clk) begin
    if (porRst || rst) begin
      alarmOn_ff <= 1'b0;
      endless_ff <= 1'b0;
      mask_ff <= 4'h0;
      alPtr_ff <= `CCAL_PTR_MINUTES_SECONDS_REG;
      repeat_ff <= 8'h00;
    end else begin
      if (wrAlCfg && wrHi) begin
        alarmOn_ff <= bus.wdata[`CCAL_AL_ON];
        endless_ff <= bus.wdata[`CCAL_AL_ENDLESS];
        mask_ff <= bus.wdata[`CCAL_AL_MASK_HI:`CCAL_AL_MASK_LO];
        alPtr_ff <= bus.wdata[`CCAL_AL_PTR_HI:`CCAL_AL_PTR_LO];
      end else if (rdAlVal || (wrAlVal && wrHi)) begin
        alPtr_ff <= ptrDown(alPtr_ff);
      end
      if (wrAlCfg && wrLo) begin
        repeat_ff <= bus.wdata[7:0];
      end
      if (alarmEvent) begin
        if (repeat_ff == 8'h00 && !endless_ff) begin
          alarmOn_ff <= 1'b0;
        end else begin
          repeat_ff <= repeat_ff - 8'h01;
        end
      end
    end
  end

  // Compare one cycle after the counters have moved
  always_ff @(posedge clk) begin
    if (porRst) begin
      evalPend_ff <= 1'b0;
      evalSec_ff <= 1'b0;
    end else begin
      evalPend_ff <= halfTick;
      evalSec_ff <= secTick;
    end
  end

  always_comb begin
    case (mask_ff)
      4'h0: matchHit = 1'b1;
      4'h1: matchHit = evalSec_ff;
      4'h2: matchHit = evalSec_ff && now_ff.sec[3:0] == alarm_ff.sec[3:0];
      4'h3: matchHit = evalSec_ff && now_ff.sec == alarm_ff.sec;
      4'h4: matchHit = evalSec_ff && now_ff.sec == alarm_ff.sec && now_ff.min[3:0] == alarm_ff.min[3:0];
      4'h5: matchHit = evalSec_ff && now_ff.sec == alarm_ff.sec && now_ff.min == alarm_ff.min;
      4'h6: matchHit = evalSec_ff && now_ff[19:0] == alarm_ff[19:0];
      4'h7: matchHit = evalSec_ff && now_ff[22:0] == alarm_ff[22:0];
      4'h8: matchHit = evalSec_ff && now_ff[19:0] == alarm_ff[19:0] && now_ff.day == alarm_ff.day;
      4'h9: matchHit = evalSec_ff && now_ff[19:0] == alarm_ff[19:0] && now_ff[33:23] == alarm_ff[33:23];
      default: matchHit = 1'b0;
    endcase
  end

  assign alarmEvent = evalPend_ff && alarmOn_ff && matchHit;

  // ---------------------------------------------------------------
  // Pad output select and pin driver
  // ---------------------------------------------------------------
  logic [1:0] pinSel_ff;
  logic padTtl_ff, alarmPulse_ff, pinLevel;

  always_ff @(posedge clk) begin
    if (porRst || rst) begin
      pinSel_ff <= `CCAL_PINSEL_ALARM;
      padTtl_ff <= 1'b0;
    end else if (wrPad && wrLo) begin
      pinSel_ff <= bus.wdata[`CCAL_PAD_SEL_HI:`CCAL_PAD_SEL_LO];
      padTtl_ff <= bus.wdata[0];
    end
  end

  // Alarm pulse held for one half second so it is visible on the pin
  always_ff @(posedge clk) begin
    if (porRst) begin
      alarmPulse_ff <= 1'b0;
    end else if (alarmEvent) begin
      alarmPulse_ff <= 1'b1;
    end else if (halfTick) begin
      alarmPulse_ff <= 1'b0;
    end
  end

  always_comb begin
    case (pinSel_ff)
      `CCAL_PINSEL_ALARM: pinLevel = alarmPulse_ff;
      `CCAL_PINSEL_SECS: pinLevel = ~halfPhase;
      `CCAL_PINSEL_TICK: pinLevel = tickLevel;
      default: pinLevel = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (porRst) begin
      pinOut <= 1'b0;
      pinOutEn <= 1'b0;
    end else begin
      pinOut <= pinOe_ff & pinLevel;
      pinOutEn <= pinOe_ff;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (porRst || rst) begin
      rdData <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        `CCAL_ADDR_CFG: rdData <= {calOn_ff, 1'b0, unlock_ff, ripple, halfPhase, pinOe_ff, timePtr_ff, trim_ff};
        `CCAL_ADDR_TIME: begin
          case (timePtr_ff)
            `CCAL_PTR_MINUTES_SECONDS_REG: rdData <= {1'b0, now_ff.min, 1'b0, now_ff.sec};
            `CCAL_PTR_WDHR: rdData <= {5'h00, now_ff.wday, 2'b00, now_ff.hour};
            `CCAL_PTR_MTHDY: rdData <= {3'h0, now_ff.month, 2'b00, now_ff.day};
            default: rdData <= {8'h00, now_ff.year};
          endcase
        end
        `CCAL_ADDR_ALCFG: rdData <= {alarmOn_ff, endless_ff, mask_ff, alPtr_ff, repeat_ff};
        `CCAL_ADDR_ALVAL: begin
          case (alPtr_ff)
            `CCAL_PTR_MINUTES_SECONDS_REG: rdData <= {1'b0, alarm_ff.min, 1'b0, alarm_ff.sec};
            `CCAL_PTR_WDHR: rdData <= {5'h00, alarm_ff.wday, 2'b00, alarm_ff.hour};
            `CCAL_PTR_MTHDY: rdData <= {3'h0, alarm_ff.month, 2'b00, alarm_ff.day};
            default: rdData <= 16'h0000;
          endcase
        end
        `CCAL_ADDR_PAD: rdData <= {13'h0000, pinSel_ff, padTtl_ff};
        default: rdData <= 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* testbench/ccal_asserts.sv */
// Checker on the clock/calendar bus answers and pin outputs
`timescale 1ns/10ps
`default_nettype none
module ccal_asserts
  import ccal_pkg::*;
#(
  parameter logic [15:0] TICKS_PER_SEC = 16'h8000
) (
  input wire logic clk, // Clock
  input wire logic porRst, // Power-on reset
  input wire ccal_bus_t bus, // Register bus request
  input wire logic [15:0] rdData, // Read data
  input wire logic pinOut, // Pin level
  input wire logic pinOutEn // Pin enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (porRst);
  wire logic rdCfg = bus.rd && bus.addr == 4'h0;
  property p_gate; !pinOutEn |-> !pinOut; endproperty
  a_gate: assert property (p_gate) else $error("pin driven while disabled");
  property p_por; $fell(porRst) |-> rdData == 16'h0000 && !pinOutEn && !pinOut; endproperty
  a_por: assert property (p_por) else $error("outputs not cleared by power-on reset");
  property p_ripple; rdCfg |=> !rdData[12] || rdData[11]; endproperty
  a_ripple: assert property (p_ripple) else $error("ripple flag outside late half");
  property p_cfg14; rdCfg |=> !rdData[14]; endproperty
  a_cfg14: assert property (p_cfg14) else $error("config bit 14 not zero");
  property p_pad; bus.rd && bus.addr == 4'h4 |=> rdData[15:3] == 13'h0000; endproperty
  a_pad: assert property (p_pad) else $error("pad config upper bits set");
  property p_tword; bus.rd && bus.addr == 4'h1 |=> !rdData[15]; endproperty
  a_tword: assert property (p_tword) else $error("time window bit 15 set");
  property p_alwin; bus.rd && bus.addr == 4'h3 |=> !rdData[15]; endproperty
  a_alwin: assert property (p_alwin) else $error("alarm window bit 15 set");
  // Pin enable may only move two edges after a high-byte config write
  property p_oe; !$stable(pinOutEn) |-> $past(bus.wr && bus.addr == 4'h0 && bus.byteEn[1], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin enable moved without config write");
endmodule
bind clock_calendar_alarm ccal_asserts #(.TICKS_PER_SEC(TICKS_PER_SEC)) ccal_asserts_i (.clk(clk),
  .porRst(porRst), .bus(bus), .rdData(rdData), .pinOut(pinOut), .pinOutEn(pinOutEn));
`default_nettype wire

/* testbench/clock_calendar_alarm_test.sv */
// Self-checking bench for the clock/calendar block
`timescale 1ns/10ps
`default_nettype none
module clock_calendar_alarm_test;
  import ccal_pkg::*;
  logic clk = 0, rst = 0, porRst = 1, xTick = 0, lTick = 0, strap = 1;
  logic pinOut, pinOutEn;
  logic [15:0] rdData;
  ccal_bus_t bus = '0;
  int failures = 0, checks_done = 0, n;
  int lo[4] = '{0, 3, 95, 0}, hi[4] = '{0, 4, 105, 0}, cy[4] = '{0, 2000, 400, 400};
  clock_calendar_alarm #(.TICKS_PER_SEC(16'h0080)) clock_calendar_alarm_i (.clk(clk), .rst(rst),
    .porRst(porRst), .bus(bus), .rdData(rdData), .crystalTick(xTick), .lowPowerTick(lTick),
    .tickSourceStrap(strap), .pinOut(pinOut), .pinOutEn(pinOutEn));
  initial forever #5 clk = ~clk;
  // Two tick rates so the strap choice shows on the raw tick pin
  initial forever #20 xTick = ~xTick;
  initial forever #50 lTick = ~lTick;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobe stays up so writes can follow with no gap
  task automatic wr(logic [3:0] a, logic [15:0] d, logic [1:0] be = 2'b11);
    bus <= '{a, d, be, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(string nm, logic [3:0] a, logic [15:0] e, logic [15:0] m = 16'hFFFF);
    bus <= '{a, 16'h0000, 2'b00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(nm, e & m, rdData & m);
    @(posedge clk);
  endtask
  task automatic count(int k);
    logic p;
    bus <= '0;
    n = 0;
    p = pinOut;
    repeat (k) begin
      @(negedge clk);
      if (pinOut === 1'b1 && p === 1'b0)
        n++;
      p = pinOut;
    end
    @(posedge clk);
  endtask
  task automatic rise();
    int t;
    bus <= '0;
    for (t = 0; t < 1200 && pinOut !== 1'b0; t++) @(negedge clk);
    for (t = t; t < 1200 && pinOut !== 1'b1; t++) @(negedge clk);
    chk("alarm pulse", 16'h0001, 16'(t < 1200));
    @(posedge clk);
  endtask
  task automatic rdTime(logic [15:0] md, logic [15:0] wh, logic [15:0] ms);
    wr(4'h0, 16'hA300);
    rd("year", 4'h1, 16'h0024);
    rd("month day", 4'h1, md);
    rd("wday hour", 4'h1, wh);
    rd("min sec", 4'h1, ms);
    rd("min sec held", 4'h1, ms);
  endtask
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    porRst <= 1'b0;
    @(posedge clk);
    rd("cfg", 4'h0, 16'h0000, 16'hE7FF);
    rd("alcfg", 4'h2, 16'h0000);
    rd("pad", 4'h4, 16'h0000);
    rd("unmapped", 4'hF, 16'h0000);
    wr(4'h5, 16'h0055);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h00AA);
    wr(4'h0, 16'hA000);
    rd("aborted key", 4'h0, 16'h0000, 16'hA000);
    wr(4'h5, 16'h0055);
    wr(4'h5, 16'h00AA);
    wr(4'h0, 16'h2300);
    wr(4'h0, 16'hA300);
    rd("unlocked", 4'h0, 16'hA300, 16'hE7FF);
    wr(4'h1, 16'h0024);
    wr(4'h1, 16'h0228);
    wr(4'h1, 16'h0523);
    wr(4'h1, 16'h5958);
    rdTime(16'h0228, 16'h0523, 16'h5958);
    count(1100);
    rdTime(16'h0229, 16'h0600, 16'h0000);
    wr(4'h1, 16'h0010, 2'b01);
    rd("half early", 4'h0, 16'h0000, 16'h0800);
    count(300);
    rd("half late", 4'h0, 16'h0800, 16'h0800);
    wr(4'h1, 16'h0010, 2'b01);
    rd("half cleared", 4'h0, 16'h0000, 16'h0800);
    // Alarm window written through its pointer, then read back from the empty code down
    wr(4'h2, 16'h0200);
    wr(4'h3, 16'h0229);
    wr(4'h3, 16'h0200);
    wr(4'h3, 16'h0012);
    wr(4'h2, 16'h0300);
    rd("al none", 4'h3, 16'h0000);
    rd("al md", 4'h3, 16'h0229);
    rd("al wh", 4'h3, 16'h0200);
    rd("al ms", 4'h3, 16'h0012);
    // Weekly alarm: seconds to hours match at :12 but weekday 6 is not 2
    wr(4'h2, 16'h9C00);
    count(1100);
    rd("week miss", 4'h2, 16'h9C00);
    // Daily alarm on 00:00:13 fires once and, with no repeats left, switches off
    wr(4'h3, 16'h0013);
    wr(4'h2, 16'h9800);
    count(500);
    rd("day hit", 4'h2, 16'h1800);
    wr(4'h0, 16'h8300);
    wr(4'h1, 16'h0077);
    wr(4'h0, 16'h8700);
    rd("relocked", 4'h0, 16'h8700, 16'hE7FF);
    rd("year kept", 4'h1, 16'h0024);
    wr(4'h2, 16'hC400);
    rise();
    rd("endless", 4'h2, 16'hC4FF);
    wr(4'h2, 16'h8401);
    rise();
    rd("repeat", 4'h2, 16'h8400);
    rise();
    rd("alarm off", 4'h2, 16'h0400);
    wr(4'h2, 16'hA800);
    count(1100);
    chk("reserved mask", 16'h0000, 16'(n));
    for (int s = 3; s > 0; s--) begin
      wr(4'h4, 16'(s * 2));
      count(cy[s]);
      chk("pin rises", 16'h0001, 16'(n >= lo[s] && n <= hi[s]));
    end
    wr(4'h0, 16'h8000);
    count(600);
    chk("pin off", 16'h0000, 16'(n) | 16'(pinOutEn));
    rst <= 1'b1;
    count(16);
    rst <= 1'b0;
    count(2);
    rd("cfg kept", 4'h0, 16'h8000, 16'hE7FF);
    rd("alcfg reset", 4'h2, 16'h0000);
    summarize();
  end
  // The sequence needs about 10000 cycles; twice that means a hang
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
